// ---- inc/start_trig_pkg.sv ----
/*
  Package for the start-condition trigger of an I2C controller.
  Assumes a 40 MHz aclk and an AXI4-Lite register slave in the core.
*/
package start_trig_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [3:0] ctrl_off = 4'h0;
  localparam logic [3:0] stat_off = 4'h4;
  localparam logic [3:0] irq_stat_off = 4'h8;
  localparam logic [3:0] irq_mask_off = 4'hc;

  // ****************************************
  // Field positions
  // ****************************************
  // Control register
  localparam int ctl_start_bit = 0;
  localparam int ctl_enable_bit = 1;
  localparam int ctl_rsv_dis_bit = 2;
  localparam int ctl_exit_bit = 3;
  localparam int ctl_wrel_bit = 4;
  localparam int ctl_ack_bit = 5;
  // Status register
  localparam int st_pending_bit = 0;
  localparam int st_master_bit = 1;
  localparam int st_busy_bit = 2;
  localparam int st_wait_bit = 3;
  localparam int st_fail_bit = 4;
  // Interrupt bits
  localparam int irq_fail_bit = 0;
  localparam int irq_start_bit = 1;
  localparam int irq_lost_bit = 2;
  localparam int irq_width = 3;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [5:0] ctrl_reset = 6'h00;
  localparam logic [2:0] irq_mask_reset = 3'h0;
  localparam int clk_mhz = 40;
  localparam int hold_ns = 4000;
  localparam int hold_cycles = (hold_ns * clk_mhz + 999) / 1000;
  localparam int setup_ns = 4700;
  localparam int setup_cycles = (setup_ns * clk_mhz + 999) / 1000;

  // ****************************************
  // Start generator states
  // ****************************************
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_setup = 3'b001,
    st_hold = 3'b010,
    st_wait = 3'b011,
    st_rs_rise = 3'b100
  } gen_state_t;

endpackage : start_trig_pkg

// ---- core/start_trigger.sv ----
/*
  Start-condition trigger with AXI4-Lite register slave and bus pins.
  Assumes the bus pins are open drain, resolved outside, and sampled
  here through two flip-flops; one clock, synchronous active-low reset.
*/
// Chosen here: the placing of the registers and register access over AXI4-Lite.
// Overview of operation
// - No start while trigger is zero
// - Free bus: data falls, clock high
// - After hold, pull clock low, wait
// - Busy and reservation on: start later
// - Busy and reservation off: flag, clear
// - Master waiting: repeated start after release
// - Further trigger writes ignored until clear
// - Clear on loss, start, exit, disable
// - Trigger always reads back as zero
`timescale 1ns/1ps
module start_trigger
  import start_trig_pkg::*;
#(
  parameter int hold_cyc = hold_cycles,
  parameter int setup_cyc = setup_cycles
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Bus pins, open drain
  input wire logic serial_clock_line_i,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe,
  // Arbitration loss from the shifter
  input wire logic arb_lost,
  // Interrupt
  output logic irq
);

  // Counters are 16 bits wide; longer times cannot be served
  if (hold_cyc < 1 || hold_cyc > 65535 ||
      setup_cyc < 1 || setup_cyc > 65535) begin : g_bad_counts
    $error("start_trigger: counts out of range");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_p;
    logic sda_p;
    logic busy;
    logic master;
    logic trig;
    logic en;
    logic rsv_dis;
    logic ack;
    logic fail;
    logic [irq_width-1:0] ist;
    logic [irq_width-1:0] imask;
    gen_state_t gs;
    logic [15:0] cnt;
    logic aw_h;
    logic w_h;
    logic [3:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bv;
    logic rv;
    logic [31:0] rd;
  } state_t;

  state_t q, d;

  logic scl, sda, start_seen, stop_seen, wr_go, rd_go, ctl_wr, trig_wr;
  logic [irq_width-1:0] ev;

  // Second synchroniser stage is the only pin view used by logic
  assign scl = q.scl_s[1];
  assign sda = q.sda_s[1];
  assign start_seen = q.scl_p && scl && q.sda_p && !sda;
  assign stop_seen = q.scl_p && scl && !q.sda_p && sda;
  assign wr_go = q.aw_h && q.w_h && !q.bv;
  assign rd_go = arvalid && !q.rv;
  assign ctl_wr = wr_go && q.aw_a == ctrl_off && q.w_s[0];
  assign trig_wr = ctl_wr && q.w_d[ctl_start_bit];

  // Handshake outputs are combinational
  assign awready = !q.aw_h;
  assign wready = !q.w_h;
  assign arready = !q.rv;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    d = q;
    ev = '0;
    d.scl_s = {q.scl_s[0], serial_clock_line_i};
    d.sda_s = {q.sda_s[0], serial_data_line_i};
    d.scl_p = scl;
    d.sda_p = sda;
    // Bus busy tracking from start/stop seen on the pins
    if (start_seen) begin
      d.busy = 1'b1;
    end else if (stop_seen) begin
      d.busy = 1'b0;
      d.master = 1'b0;
    end
    // Write channel capture
    if (awvalid && !q.aw_h) begin
      d.aw_h = 1'b1;
      d.aw_a = awaddr;
    end
    if (wvalid && !q.w_h) begin
      d.w_h = 1'b1;
      d.w_d = wdata;
      d.w_s = wstrb;
    end
    if (q.bv && bready) begin
      d.bv = 1'b0;
    end
    if (wr_go) begin
      d.aw_h = 1'b0;
      d.w_h = 1'b0;
      d.bv = 1'b1;
      if (q.aw_a == ctrl_off && q.w_s[0]) begin
        d.en = q.w_d[ctl_enable_bit];
        d.rsv_dis = q.w_d[ctl_rsv_dis_bit];
        d.ack = q.w_d[ctl_ack_bit];
      end
      if (q.aw_a == irq_mask_off && q.w_s[0]) begin
        d.imask = q.w_d[irq_width-1:0];
      end
    end
    // Trigger write is taken only while the trigger is clear
    if (trig_wr && !q.trig && q.en) begin
      if ((q.busy || !sda || !scl) && !q.master && q.rsv_dis) begin
        d.fail = 1'b1;
        ev[irq_fail_bit] = 1'b1;
      end else begin
        d.trig = 1'b1;
        d.fail = 1'b0;
      end
    end
    // Start generator
    unique case (q.gs)
      st_idle: begin
        d.cnt = '0;
        if (q.trig && !q.busy && scl && sda) begin
          d.gs = st_setup;
        end
      end
      st_setup: begin
        // Keep the free bus stable for a setup time before pulling data low
        d.cnt = q.cnt + 16'h0001;
        if (q.busy) begin
          d.gs = st_idle;
        end else if (q.cnt == 16'(setup_cyc - 1)) begin
          d.gs = st_hold;
          d.cnt = '0;
          d.trig = 1'b0;
          d.master = 1'b1;
          ev[irq_start_bit] = 1'b1;
        end
      end
      st_hold: begin
        d.cnt = q.cnt + 16'h0001;
        if (q.cnt == 16'(hold_cyc - 1)) begin
          d.gs = st_wait;
          d.cnt = '0;
        end
      end
      st_wait: begin
        // Clock held low; wait release with trigger set gives repeated start
        d.cnt = '0;
        if (ctl_wr && q.w_d[ctl_wrel_bit]) begin
          d.gs = q.trig ? st_rs_rise : st_idle;
        end
      end
      st_rs_rise: begin
        d.cnt = q.cnt + 16'h0001;
        // A clock still held low by a slow peer delays the restart, never loses it
        if (q.cnt >= 16'(setup_cyc - 1) && scl) begin
          d.gs = st_hold;
          d.cnt = '0;
          d.trig = 1'b0;
          ev[irq_start_bit] = 1'b1;
        end
      end
      default: begin
        d.gs = st_idle;
      end
    endcase
    // Clearing conditions win over the generator
    if (arb_lost && q.master) begin
      ev[irq_lost_bit] = 1'b1;
    end
    if (arb_lost || !q.en || (ctl_wr && q.w_d[ctl_exit_bit])) begin
      d.trig = 1'b0;
      d.gs = st_idle;
      d.master = 1'b0;
    end
    if (ctl_wr && q.w_d[ctl_exit_bit]) begin
      d.busy = 1'b0;
    end
    // Interrupt status: write one clears, a new event wins
    if (wr_go && q.aw_a == irq_stat_off && q.w_s[0]) begin
      d.ist = q.ist & ~q.w_d[irq_width-1:0];
    end
    d.ist = d.ist | ev;
    // Read channel
    if (q.rv && rready) begin
      d.rv = 1'b0;
    end
    if (rd_go) begin
      d.rv = 1'b1;
      d.rd = '0;
      unique case (araddr)
        ctrl_off: begin
          // Trigger field reads zero
          d.rd[ctl_enable_bit] = q.en;
          d.rd[ctl_rsv_dis_bit] = q.rsv_dis;
          d.rd[ctl_ack_bit] = q.ack;
        end
        stat_off: begin
          d.rd[st_pending_bit] = q.trig;
          d.rd[st_master_bit] = q.master;
          d.rd[st_busy_bit] = q.busy;
          d.rd[st_wait_bit] = q.gs == st_wait;
          d.rd[st_fail_bit] = q.fail;
        end
        irq_stat_off: d.rd[irq_width-1:0] = q.ist;
        irq_mask_off: d.rd[irq_width-1:0] = q.imask;
        default: d.rd = '0;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.scl_s <= 2'h3;
      q.sda_s <= 2'h3;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.imask <= irq_mask_reset;
    end else begin
      q <= d;
    end
  end

  // Outputs from flip-flops; drive low only, release means high
  assign serial_data_line_o = 1'b0;
  assign serial_clock_line_o = 1'b0;
  assign serial_data_line_oe = q.gs == st_hold || q.gs == st_wait;
  assign serial_clock_line_oe = q.gs == st_wait;
  assign bvalid = q.bv;
  assign bresp = 2'h0;
  assign rvalid = q.rv;
  assign rdata = q.rd;
  assign rresp = 2'h0;
  assign irq = |(q.ist & q.imask);

  // ****************************************
  // Assertions
  // ****************************************
  property p_no_start_idle;
    @(posedge aclk) disable iff (!aresetn)
      (q.gs == st_idle && !q.trig) |=> !serial_data_line_oe;
  endproperty
  a_no_start_idle: assert property (p_no_start_idle) else $error("start without trigger");

  property p_sda_first;
    @(posedge aclk) disable iff (!aresetn)
      $rose(serial_data_line_oe) && !$past(serial_clock_line_oe) |-> !serial_clock_line_oe;
  endproperty
  a_sda_first: assert property (p_sda_first) else $error("clock fell with data");

  property p_hold_then_wait;
    @(posedge aclk) disable iff (!aresetn)
      (q.gs == st_hold && q.cnt == 16'(hold_cyc - 1) && !arb_lost && q.en &&
        !(ctl_wr && q.w_d[ctl_exit_bit])) |=> serial_clock_line_oe;
  endproperty
  a_hold_then_wait: assert property (p_hold_then_wait) else $error("no wait after hold");

  property p_fail_no_trig;
    @(posedge aclk) disable iff (!aresetn)
      (trig_wr && !q.trig && q.en && q.busy && !q.master && q.rsv_dis)
        |=> (q.fail && !q.trig);
  endproperty
  a_fail_no_trig: assert property (p_fail_no_trig) else $error("failure not flagged");

  property p_reserve;
    @(posedge aclk) disable iff (!aresetn)
      (trig_wr && !q.trig && q.en && !q.rsv_dis && !arb_lost && !q.w_d[ctl_exit_bit])
        |=> q.trig;
  endproperty
  a_reserve: assert property (p_reserve) else $error("reservation not held");

  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
      (arb_lost || !q.en) |=> !q.trig;
  endproperty
  a_clear: assert property (p_clear) else $error("trigger not cleared");

  property p_read_zero;
    @(posedge aclk) disable iff (!aresetn)
      (rd_go && araddr == ctrl_off) |=> !rdata[ctl_start_bit];
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("trigger read non-zero");

  property p_no_retrig;
    @(posedge aclk) disable iff (!aresetn)
      (q.trig && q.fail == 1'b0 && q.gs == st_idle) |=> !$rose(q.fail);
  endproperty
  a_no_retrig: assert property (p_no_retrig) else $error("write taken while set");

endmodule : start_trigger

// ---- test/bus_peer.sv ----
/*
  Far side of the bus: a third-party master that can hold a frame.
  Assumes open-drain lines with pull-ups; the bench raises hold.
*/
`timescale 1ns/1ps
module bus_peer (
  // Frame request from the bench
  input wire logic hold,
  // Device pull-downs
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  // Resolved line levels
  output logic scl,
  output logic sda
);
  logic clk_low;
  logic data_low;

  initial begin
    clk_low = 1'b0;
    data_low = 1'b0;
  end

  // 200 ns peer clock, standing still high outside its own frame; the frame
  // opens with data falling under a high clock and closes with a real stop
  always begin
    #100;
    if (hold && !data_low) begin
      data_low = 1'b1;
    end else if (hold) begin
      clk_low = ~clk_low;
    end else if (clk_low) begin
      clk_low = 1'b0;
    end else begin
      data_low = 1'b0;
    end
  end

  // Wired-and with pull-ups; data held low for the whole frame
  assign scl = ~(dev_scl_oe | clk_low);
  assign sda = ~(dev_sda_oe | data_low);
endmodule : bus_peer

// ---- test/tb_start_trigger.sv ----
/*
  Self-checking bench for the start trigger over AXI4-Lite.
  Assumes bus_peer as third party and short hold and setup counts.
*/
`timescale 1ns/1ps
module tb_start_trigger;
  import start_trig_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, arb_lost, irq, hold;
  logic scl, sda, scl_o, scl_oe, sda_o, sda_oe, sda_prev;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] bresp, rresp;
  int num_errors = 0;
  int checks = 0;
  int starts = 0;
  int bad = 0;

  start_trigger #(.hold_cyc(4), .setup_cyc(4)) start_trigger_i (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .serial_clock_line_i(scl), .serial_clock_line_o(scl_o),
    .serial_clock_line_oe(scl_oe), .serial_data_line_i(sda), .serial_data_line_o(sda_o),
    .serial_data_line_oe(sda_oe), .arb_lost(arb_lost), .irq(irq));
  bus_peer bus_peer_i (.hold(hold), .dev_scl_oe(scl_oe), .dev_sda_oe(sda_oe),
    .scl(scl), .sda(sda));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Count starts; a data fall with the clock pulled low still counts, and also counts as bad
  always @(posedge aclk) begin
    sda_prev <= sda_oe;
    if (sda_oe === 1'b1 && sda_prev === 1'b0) begin
      starts <= starts + 1;
      if (scl_oe !== 1'b0) bad <= bad + 1;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Handshakes are judged at the rising edge; one idle edge ends each
  // task so a following call never re-drives a strobe in the same step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      done = bvalid && bready;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      done = rvalid && rready;
    end
    rv = rdata;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Bounded wait for a given number of starts
  task automatic wait_starts(input int n);
    for (int i = 0; i < 300 && starts < n; i++) @(posedge aclk);
  endtask : wait_starts

  task automatic close_out;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(25 * 40000);
    num_errors++;
    close_out();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; arb_lost = 1'b0; hold = 1'b0; awaddr = 4'h0; araddr = 4'h0;
    wdata = 32'h0; wstrb = 4'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(ctrl_off); chk(rv, 32'h0);
    rd(stat_off); chk(rv, 32'h0);
    rd(irq_mask_off); chk(rv, 32'h0);
    wr(irq_mask_off, 32'h7);
    wr(ctrl_off, 32'h2);
    repeat (30) @(posedge aclk);
    chk(starts, 0);
    $display("reset and idle done");
    // Start on a free bus, then wait state
    wr(ctrl_off, 32'h3);
    rd(ctrl_off); chk(rv & 32'h1, 32'h0);
    wait_starts(1);
    for (int i = 0; i < 100 && scl_oe !== 1'b1; i++) @(posedge aclk);
    chk(starts, 1);
    chk(bad, 0);
    rd(stat_off); chk(rv & 32'ha, 32'ha);
    rd(irq_stat_off); chk(rv, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(irq_stat_off, 32'h2);
    chk({31'h0, irq}, 32'h0);
    // Trigger in the wait state, then release the wait
    wr(ctrl_off, 32'h3);
    wr(ctrl_off, 32'h13);
    wait_starts(2);
    chk(starts, 2);
    wr(irq_stat_off, 32'h2);
    // Arbitration lost while master: event flagged, mastership dropped
    arb_lost <= 1'b1;
    @(posedge aclk);
    arb_lost <= 1'b0;
    rd(irq_stat_off); chk(rv & 32'h6, 32'h4);
    rd(stat_off); chk(rv & 32'h3, 32'h0);
    wr(ctrl_off, 32'ha);
    repeat (10) @(posedge aclk);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    $display("start and restart done");
    // Reservation while a third party holds the bus
    hold <= 1'b1;
    repeat (10) @(posedge aclk);
    wr(ctrl_off, 32'h3);
    wr(ctrl_off, 32'h3);
    rd(stat_off); chk(rv & 32'h11, 32'h1);
    chk(starts, 2);
    hold <= 1'b0;
    wait_starts(3);
    chk(starts, 3);
    rd(stat_off); chk(rv & 32'h1, 32'h0);
    wr(ctrl_off, 32'ha);
    wr(irq_stat_off, 32'h7);
    $display("reservation done");
    // Reservation off: refused with failure flag
    hold <= 1'b1;
    repeat (10) @(posedge aclk);
    wr(ctrl_off, 32'h6);
    wr(ctrl_off, 32'h7);
    rd(stat_off); chk(rv & 32'h11, 32'h10);
    rd(irq_stat_off); chk(rv & 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(irq_stat_off, 32'h1);
    // Trigger refused with reservation still off, arbitration loss with none pending, then pending trigger lost to disable
    wr(ctrl_off, 32'h3);
    arb_lost <= 1'b1;
    @(posedge aclk);
    arb_lost <= 1'b0;
    rd(stat_off); chk(rv & 32'h1, 32'h0);
    wr(ctrl_off, 32'h3);
    wr(ctrl_off, 32'h0);
    rd(stat_off); chk(rv & 32'h1, 32'h0);
    hold <= 1'b0;
    repeat (40) @(posedge aclk);
    chk(starts, 3);
    chk({28'h0, bresp, rresp}, 32'h0);
    chk({30'h0, scl_o, sda_o}, 32'h0);
    $display("refusal and clearing done");
    close_out();
  end
endmodule : tb_start_trigger
